// File: src/reference_calibration_regs.sv
// Purpose: apb slave holding the reference calibration register bank
// Assumes: one wait state per transfer; synchronous active-high reset
// Notes:   unmapped addresses read zero and answer with pslverr
`timescale 1ns/1ps
`default_nettype none

// register map; the byte address is four times the register index
//    060h  offset calibration select: range code in bits 2..0
//    064h  reference margin offset: buffer offset code in bits 4..0
//    068h  reference margin enable: margin apply in bit 0
//    06ch  half-reference margin: offset in bits 6..4, apply in bit 0
// any other word, or an address that is not word aligned, is refused

// bus timing, counted from the setup cycle c0
//    c0  psel high, penable low; nothing is taken yet
//    c1  psel and penable high; the answer is loaded into flops
//    c2  pready high with prdata and pslverr; a write lands at its closing edge
//    c3  idle, or the setup cycle of the next transfer
// the wait state is always exactly one cycle; it buys bus outputs that leave
// flops directly, at the price of one extra cycle on every access
// a master that keeps penable high after pready would start a second answer,
// so the bank relies on penable falling after every completed transfer

// a refused access still completes after the same wait state, with pslverr
// high and prdata zero; a write to it changes nothing in the bank

// reserved bits are cleared on the way in by the write mask, so the stored
// bytes never hold a reserved one and the read path needs no mask of its own
// only byte lane 0 carries register data; with pstrb[0] low a write is dropped
// silently, since nothing on the other lanes could be refused

// range codes above the last defined one are stored and read back as written,
// while the decoder shows them as the 5.0 v code on the range output
// the setting outputs trail the register store by one edge, so the analog side
// sees a new margin one cycle after the write completes

// reset is synchronous: one edge with reset high clears every register, the
// bus answer and the settings together; a transfer cut by reset is lost
// the bank has no write lock: every mapped register is writable at all times

// the settings decoder sits behind an interface so that it can be placed next
// to the analog trims; it reads only the stored bytes, never the bus

// Overview of operation
// - offset calibration select bits 7..3 always read back as zero.
// - 3-bit range field in bits 2..0, reset 000; codes 110/111 act as 5.0 V.
// - margin offset register at 19h, reset 00h, upper three bits read zero.
// - 5-bit signed-step offset code in bits 4..0, reset 00000.
// - margin enable register at 1Ah, reset 00h, bits 7..1 read zero.
// - enable bit 0 applies the margin offset code to the reference buffer.
// - half-reference margin register at 1Bh, reset 00h, selects its margin.
module reference_calibration_regs
   import refcal_pkg::*;
(
   // clock and reset
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_reset,
   // apb slave
   input  wire logic                  i_psel,
   input  wire logic                  i_penable,
   input  wire logic                  i_pwrite,
   input  wire logic [11:0]           i_paddr,
   input  wire logic [31:0]           i_pwdata,
   input  wire logic [3:0]            i_pstrb,
   output logic                       o_pready,
   output logic [31:0]                o_prdata,
   output logic                       o_pslverr,
   // calibration settings
   output ref_range_e                 o_range,
   output logic [OFS_CODE_W-1:0]      o_buffer_offset_code,
   output logic                       o_margin_apply,
   output logic [HALF_OFS_W-1:0]      o_half_offset_code,
   output logic                       o_half_margin_apply
);
   // all bank state: four stored bytes and the registered bus answer
   typedef struct packed {
      logic [7:0]  cal_sel;
      logic [7:0]  margin_ofs;
      logic [7:0]  margin_en;
      logic [7:0]  half_marg;
      logic        ready;
      logic [31:0] rdata;
      logic        slverr;
   } bank_state_s;

   // result of one address decode
   typedef struct packed {
      logic       hit;
      logic [1:0] sel;
      logic [7:0] mask;
   } decode_t;

   // register slots as carried in the decode result
   localparam logic [1:0] SLOT_CAL  = 2'h0;
   localparam logic [1:0] SLOT_OFS  = 2'h1;
   localparam logic [1:0] SLOT_EN   = 2'h2;
   localparam logic [1:0] SLOT_HALF = 2'h3;

   bank_state_s state_reg;
   bank_state_s state_next;
   decode_t     dec;
   logic [7:0]  rd_byte;
   logic        access_first; // first access cycle: the answer is loaded
   logic        access_done;  // completing cycle: pready is high
   logic [7:0]  wr_byte;      // lane 0 with reserved bits cleared
   logic        wr_any;       // a write that the bank accepts
   logic        wr_cal;       // one write strobe per register
   logic        wr_ofs;
   logic        wr_en;
   logic        wr_half;

   refcal_if regs_bus ();

   // map a byte address to a register slot and its writable mask
   function automatic decode_t addr_decode(input logic [11:0] addr);
      decode_t    d;
      logic [9:0] idx;
      d   = '{hit: 1'b0, sel: 2'h0, mask: 8'h00};
      idx = addr[11:ADDR_LSB];
      // low address bits must be zero; a misaligned word never hits
      if (addr[ADDR_LSB-1:0] == 2'h0) begin
         unique case (idx)
            {2'h0, OFFSET_CAL_SEL_IDX}: d = '{hit: 1'b1, sel: 2'h0, mask: OFFSET_CAL_SEL_MASK};
            {2'h0, REF_MARGIN_OFS_IDX}: d = '{hit: 1'b1, sel: 2'h1, mask: REF_MARGIN_OFS_MASK};
            {2'h0, REF_MARGIN_EN_IDX}:  d = '{hit: 1'b1, sel: 2'h2, mask: REF_MARGIN_EN_MASK};
            {2'h0, HALF_REF_MARG_IDX}:  d = '{hit: 1'b1, sel: 2'h3, mask: HALF_REF_MARG_MASK};
            default:                    d = '{hit: 1'b0, sel: 2'h0, mask: 8'h00};
         endcase
      end
      return d;
   endfunction

   // one decode per cycle, shared by the read mux and the write strobes
   assign dec = addr_decode(i_paddr);

   // phase qualifiers; the ready flop tells the first access cycle from the last
   assign access_first = i_psel && i_penable && !state_reg.ready;
   assign access_done  = i_psel && i_penable && state_reg.ready;

   // a write needs a mapped word and lane 0; anything else leaves the bank alone
   assign wr_byte = i_pwdata[7:0] & dec.mask;
   assign wr_any  = access_done && i_pwrite && dec.hit && i_pstrb[0];
   assign wr_cal  = wr_any && (dec.sel == SLOT_CAL);
   assign wr_ofs  = wr_any && (dec.sel == SLOT_OFS);
   assign wr_en   = wr_any && (dec.sel == SLOT_EN);
   assign wr_half = wr_any && (dec.sel == SLOT_HALF);

   // read mux; stored bytes never hold reserved ones
   // an unmapped access reads slot 0 here; the answer is zeroed before it leaves
   always_comb begin
      unique case (dec.sel)
         2'h0:    rd_byte = state_reg.cal_sel;
         2'h1:    rd_byte = state_reg.margin_ofs;
         2'h2:    rd_byte = state_reg.margin_en;
         default: rd_byte = state_reg.half_marg;
      endcase
   end

   // one wait state lets prdata come from a flop rather than the mux
   always_comb begin
      state_next        = state_reg;
      // pready and pslverr are one-cycle pulses; they drop unless reloaded
      state_next.ready  = 1'b0;
      state_next.slverr = 1'b0;
      // first access cycle: load the whole answer so that c2 shows it from flops
      if (access_first) begin
         state_next.ready  = 1'b1;
         state_next.slverr = !dec.hit;
         state_next.rdata  = (dec.hit && !i_pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
      end
      // writes land on the edge that completes the access phase
      if (wr_cal) begin
         state_next.cal_sel = wr_byte;
      end
      if (wr_ofs) begin
         state_next.margin_ofs = wr_byte;
      end
      if (wr_en) begin
         state_next.margin_en = wr_byte;
      end
      if (wr_half) begin
         state_next.half_marg = wr_byte;
      end
      // synchronous reset overrides everything, the bus answer included
      if (i_reset) begin
         state_next            = '0;
         state_next.cal_sel    = REG_RESET;
         state_next.margin_ofs = REG_RESET;
         state_next.margin_en  = REG_RESET;
         state_next.half_marg  = REG_RESET;
      end
   end

   // single state register
   // no reset term here; reset is folded into the next-state logic above
   always_ff @(posedge i_sys_clk) begin
      state_reg <= state_next;
   end

   // stored bytes to the decoder; reserved bits are already zero
   assign regs_bus.cal_sel    = state_reg.cal_sel;
   assign regs_bus.margin_ofs = state_reg.margin_ofs;
   assign regs_bus.margin_en  = state_reg.margin_en;
   assign regs_bus.half_marg  = state_reg.half_marg;

   // bus answer straight from the state flops
   assign o_pready  = state_reg.ready;
   assign o_prdata  = state_reg.rdata;
   assign o_pslverr = state_reg.slverr; // only ever set together with ready

   // settings decoder, registered outputs
   // the decoder resets itself on the same edge as the bank
   refcal_decode u_decode (
      .i_sys_clk            (i_sys_clk),
      .i_reset              (i_reset),
      .regs                 (regs_bus),
      .o_range              (o_range),
      .o_buffer_offset_code (o_buffer_offset_code),
      .o_margin_apply       (o_margin_apply),
      .o_half_offset_code   (o_half_offset_code),
      .o_half_margin_apply  (o_half_margin_apply)
   );
endmodule
`default_nettype wire

// File: src/refcal_pkg.sv
// Purpose: shared constants for the reference calibration register bank
// Assumes: register indices times four give the apb byte address
// Notes:   all registers reset to zero
package refcal_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] OFFSET_CAL_SEL_IDX = 8'h18;
   localparam logic [7:0] REF_MARGIN_OFS_IDX = 8'h19;
   localparam logic [7:0] REF_MARGIN_EN_IDX  = 8'h1a;
   localparam logic [7:0] HALF_REF_MARG_IDX  = 8'h1b;
   localparam int         ADDR_LSB           = 2;

   // field positions and widths
   localparam int RANGE_SEL_W   = 3;
   localparam int OFS_CODE_W    = 5;
   localparam int HALF_OFS_LSB  = 4;
   localparam int HALF_OFS_W    = 3;
   localparam int HALF_EN_BIT   = 0;
   localparam int APPLY_BIT     = 0;

   // writable bits of each register; everything else is reserved
   localparam logic [7:0] OFFSET_CAL_SEL_MASK = 8'h07;
   localparam logic [7:0] REF_MARGIN_OFS_MASK = 8'h1f;
   localparam logic [7:0] REF_MARGIN_EN_MASK  = 8'h01;
   localparam logic [7:0] HALF_REF_MARG_MASK  = 8'h71;

   // values after reset
   localparam logic [7:0] REG_RESET = 8'h00;

   // reference range codes
   typedef enum logic [2:0] {
      RANGE_5V0   = 3'h0,
      RANGE_4V5   = 3'h1,
      RANGE_4V096 = 3'h2,
      RANGE_3V3   = 3'h3,
      RANGE_3V0   = 3'h4,
      RANGE_2V5   = 3'h5
   } ref_range_e;
endpackage

// File: src/refcal_if.sv
// Purpose: carries the stored register contents to the setting decoder
// Assumes: single clock domain
// Notes:   values are raw register bytes, reserved bits already zero
`timescale 1ns/1ps
`default_nettype none
interface refcal_if;
   logic [7:0] cal_sel;
   logic [7:0] margin_ofs;
   logic [7:0] margin_en;
   logic [7:0] half_marg;

   modport src (output cal_sel, margin_ofs, margin_en, half_marg);
   modport dst (input  cal_sel, margin_ofs, margin_en, half_marg);
endinterface
`default_nettype wire

// File: src/refcal_decode.sv
// Purpose: turns stored register bytes into registered analog settings
// Assumes: inputs change only on apb writes
// Notes:   one cycle of latency from register to setting output
`timescale 1ns/1ps
`default_nettype none
module refcal_decode
   import refcal_pkg::*;
(
   // clock and reset
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_reset,
   // stored register contents
   refcal_if.dst                      regs,
   // settings
   output ref_range_e                 o_range,
   output logic [OFS_CODE_W-1:0]      o_buffer_offset_code,
   output logic                       o_margin_apply,
   output logic [HALF_OFS_W-1:0]      o_half_offset_code,
   output logic                       o_half_margin_apply
);
   typedef struct packed {
      ref_range_e            range;
      logic [OFS_CODE_W-1:0] ofs;
      logic                  apply;
      logic [HALF_OFS_W-1:0] half_ofs;
      logic                  half_apply;
   } dec_state_s;

   dec_state_s state_reg;
   dec_state_s state_next;

   // settings follow the registers; unused range codes fold onto 5.0 v
   always_comb begin
      state_next = state_reg;
      if (regs.cal_sel[RANGE_SEL_W-1:0] > RANGE_2V5) begin
         state_next.range = RANGE_5V0;
      end else begin
         state_next.range = ref_range_e'(regs.cal_sel[RANGE_SEL_W-1:0]);
      end
      state_next.apply      = regs.margin_en[APPLY_BIT];
      // the code only reaches the buffer while margining is on
      state_next.ofs        = state_next.apply ? regs.margin_ofs[OFS_CODE_W-1:0] : '0;
      state_next.half_apply = regs.half_marg[HALF_EN_BIT];
      state_next.half_ofs   = regs.half_marg[HALF_OFS_LSB +: HALF_OFS_W];
      if (i_reset) begin
         state_next = '0;
      end
   end

   // single state register
   always_ff @(posedge i_sys_clk) begin
      state_reg <= state_next;
   end

   assign o_range              = state_reg.range;
   assign o_buffer_offset_code = state_reg.ofs;
   assign o_margin_apply       = state_reg.apply;
   assign o_half_offset_code   = state_reg.half_ofs;
   assign o_half_margin_apply  = state_reg.half_apply;
endmodule
`default_nettype wire

// File: dv/refcal_assertions.sv
// Purpose: concurrent checks on the register bank ports
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into the top module below
`timescale 1ns/1ps
`default_nettype none
module refcal_chk
   import refcal_pkg::*;
(
   input wire logic        i_sys_clk,
   input wire logic        i_reset,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic        o_pready,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pslverr,
   input wire ref_range_e  o_range,
   input wire logic [4:0]  o_buffer_offset_code,
   input wire logic        o_margin_apply
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   // reads are qualified by the completing cycle only
   wire rd = o_pready && i_psel && !i_pwrite;
   a_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("no answer");
   a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("pready held");
   a_err_unmap: assert property (o_pready && i_psel && i_paddr > 12'h06c |-> o_pslverr) else $error("no error");
   a_upper_zero: assert property (o_pready |-> o_prdata[31:8] == 24'h0) else $error("upper bits");
   a_cal_resv: assert property (rd && i_paddr == 12'h060 |-> o_prdata[7:3] == 5'h0) else $error("cal rsv");
   a_ofs_resv: assert property (rd && i_paddr == 12'h064 |-> o_prdata[7:5] == 3'h0) else $error("ofs rsv");
   a_en_resv: assert property (rd && i_paddr == 12'h068 |-> o_prdata[7:1] == 7'h0) else $error("en rsv");
   a_range_ok: assert property (o_range <= RANGE_2V5) else $error("range code");
   a_apply_gate: assert property (!o_margin_apply |-> o_buffer_offset_code == 5'h0) else $error("gate");
   a_reset_out: assert property ($fell(i_reset) |-> o_range == RANGE_5V0 && !o_margin_apply)
      else $error("reset out");
endmodule
bind reference_calibration_regs refcal_chk i_chk(.i_sys_clk, .i_reset, .i_psel, .i_penable, .i_pwrite,
   .i_paddr, .o_pready, .o_prdata, .o_pslverr, .o_range, .o_buffer_offset_code, .o_margin_apply);
`default_nettype wire

// File: dv/reference_calibration_regs_bench.sv
// Purpose: directed bench for the register bank
// Assumes: one wait state is not relied on; waits are bounded
// Notes:   settings are checked two edges after a write
`timescale 1ns/1ps
`default_nettype none
module reference_calibration_regs_bench;
   import refcal_pkg::*;
   logic i_sys_clk = 0, i_reset = 1, psel = 0, pen = 0, pw = 0;
   logic [11:0] pa = 12'h0;
   logic [31:0] pd = 32'h0, prd;
   logic [3:0] ps = 4'hf;
   logic rdy, err;
   ref_range_e rng;
   logic [4:0] ofs;
   logic app, happ;
   logic [2:0] hofs;
   int fails = 0, checks_done = 0, cyc = 0;
   reference_calibration_regs i_reference_calibration_regs(.i_sys_clk, .i_reset, .i_psel(psel),
      .i_penable(pen), .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pd), .i_pstrb(ps), .o_pready(rdy),
      .o_prdata(prd), .o_pslverr(err), .o_range(rng), .o_buffer_offset_code(ofs),
      .o_margin_apply(app), .o_half_offset_code(hofs), .o_half_margin_apply(happ));
   always #25 i_sys_clk = ~i_sys_clk;
   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         end_sim();
      end
   end
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   // one apb transfer; holds everything until pready is seen high
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge i_sys_clk);
      psel <= 1; pw <= w; pa <= a; pd <= d;
      @(posedge i_sys_clk);
      pen <= 1;
      do @(posedge i_sys_clk); while (rdy !== 1'b1);
      r = prd;
      e = err;
      psel <= 0; pen <= 0;
   endtask
   task automatic wr(logic [11:0] a, logic [7:0] d);
      logic [31:0] r; logic e;
      apb(1, a, {24'hffffff, d}, r, e);
      repeat (2) @(posedge i_sys_clk);
   endtask
   task automatic rd(logic [11:0] a, logic [7:0] x, logic xe = 0);
      logic [31:0] r; logic e;
      apb(0, a, 0, r, e);
      chk("prdata", {24'h0, x}, r);
      chk("pslverr", {31'h0, xe}, {31'h0, e});
   endtask
   task t_reset;
      rd(12'h060, 0);
      rd(12'h064, 0);
      rd(12'h068, 0);
      rd(12'h06c, 0);
      chk("apply", 0, app);
      chk("range", 0, rng);
      chk("ofs", 0, ofs);
      chk("half", 0, {hofs, happ});
      $display("reset test done");
   endtask
   task t_cal;
      for (int c = 0; c < 8; c++) begin
         wr(12'h060, 8'hf8 | c[7:0]);
         rd(12'h060, c[7:0]);
         chk("range", c > 5 ? 0 : c, rng);
      end
      $display("range test done");
   endtask
   task t_margin;
      wr(12'h064, 8'hff);
      rd(12'h064, 8'h1f);
      chk("ofs off", 0, ofs);
      wr(12'h068, 8'hff);
      rd(12'h068, 8'h01);
      chk("apply on", 1, app);
      chk("ofs on", 32'h1f, ofs);
      wr(12'h064, 8'h10);
      chk("ofs neg", 32'h10, ofs);
      wr(12'h068, 8'h00);
      chk("ofs gate", 0, ofs);
      $display("margin test done");
   endtask
   task t_half;
      wr(12'h06c, 8'hff);
      rd(12'h06c, 8'h71);
      chk("half", 32'hf, {hofs, happ});
      ps <= 4'h0;
      wr(12'h06c, 8'h00);
      ps <= 4'hf;
      rd(12'h06c, 8'h71);
      wr(12'h06c, 8'h5e);
      rd(12'h06c, 8'h50);
      chk("half part", 32'ha, {hofs, happ});
      rd(12'h070, 0, 1);
      rd(12'h062, 0, 1);
      $display("half and error test done");
   endtask
   // reset in mid-run must clear registers and settings alike
   task t_midreset;
      wr(12'h060, 8'h05);
      wr(12'h064, 8'h0a);
      wr(12'h068, 8'h01);
      chk("ofs before", 32'h0a, ofs);
      i_reset <= 1;
      repeat (2) @(posedge i_sys_clk);
      i_reset <= 0;
      chk("range rst", 0, rng);
      chk("ofs rst", 0, ofs);
      chk("apply rst", 0, app);
      chk("half rst", 0, {hofs, happ});
      rd(12'h060, 0);
      rd(12'h064, 0);
      rd(12'h068, 0);
      rd(12'h06c, 0);
      $display("mid-run reset test done");
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge i_sys_clk);
      i_reset <= 0;
      t_reset();
      t_cal();
      t_margin();
      t_half();
      t_midreset();
      end_sim();
   end
endmodule
`default_nettype wire
